// ### iacu_pkg.sv
package iacu_pkg;

   // ==========================================================
   // Register access
   // ==========================================================
   localparam logic [8:0] AUX_MODE_ADDR     = 9'h11b;  // Aux mode register offset
   localparam logic [2:0] SEL_AUX_COMMAND   = 3'h0;    // Bits 7-5: plain command
   localparam logic [2:0] SEL_COUNTER_DIV   = 3'h1;    // Bits 7-5: counter divisor
   localparam int         SEL_MSB           = 7;
   localparam int         SEL_LSB           = 5;
   localparam int         DATA_MSB          = 4;
   localparam int         VALUE_BIT         = 3;       // Command value bit
   localparam logic [7:0] READ_BACK_VALUE   = 8'h00;   // Hidden registers never read

   // ==========================================================
   // Auxiliary command codes (value bit masked out where paired)
   // ==========================================================
   localparam logic [4:0] CMD_LISTEN        = 5'h13;
   localparam logic [4:0] CMD_LISTEN_CONT   = 5'h1b;
   localparam logic [4:0] CMD_LOCAL_UNLISTEN = 5'h1c;
   localparam logic [4:0] CMD_EXEC_PPOLL    = 5'h1d;
   localparam logic [4:0] CMD_IFC_PAIR      = 5'h16;   // 10110 clear, 11110 set
   localparam logic [4:0] CMD_REN_PAIR      = 5'h17;   // 10111 clear, 11111 set
   localparam logic [4:0] CMD_DISABLE_SC    = 5'h14;
   localparam logic [4:0] PAIR_MASK         = 5'h17;   // Ignore the value bit

   // ==========================================================
   // Reset values and timing
   // ==========================================================
   localparam logic [4:0] COUNTER_DIV_RESET = 5'h08;
   localparam logic [3:0] DIV_ZERO_AS       = 4'hf;    // Divisor 0 behaves as 16
   localparam logic [7:0] T1_STD_TICKS      = 8'h10;   // Settling, normal transfers
   localparam logic [7:0] T1_FAST_TICKS     = 8'h04;   // Settling, high-speed data

endpackage

// ### iacu_aux_command_unit.sv
// What this block does
// - Listen-continuous command pulses ltn and enters continuous listen mode.
// - In continuous mode, pulse rdy on ANRS entry unless byte carried END.
// - END in continuous mode enters RFD holdoff and stops further rdy.
// - In continuous mode a received data byte does not set data-in flag.
// - Continuous mode ends on plain listen command or listener entering LIDS.
// - Code 11100 pulses the local unlisten message.
// - Code 11101 sets rpp; rpp clears on entering CPPS or CIDS.
// - Set/clear IFC commands assert rsc and drive IFC to value bit.
// - Set/clear REN commands assert rsc and drive REN to value bit.
// - Code 10100 clears rsc and the system controller bit.
// - Aux write: bits 7-5 pick hidden register, bits 4-0 are its data.
// - Hidden registers are write-only; reads never return their contents.
// - Set-only hidden bits reset only by chip reset, power-on or local reset.
// - Aux write with select 001 loads the counter divisor register.
// - Divisor bits 3-0 scale the counters timing state-change delays.
// - T1 settling delay before DAV, by transfer type and high-speed select.
module iacu_aux_command_unit
(
   // Clock and reset
   input  wire logic       REF_CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic       LOCAL_MASTER_RESET_IN,
   // Host register port
   input  wire logic [8:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       REG_WR_STB_IN,
   input  wire logic       REG_RD_STB_IN,
   output logic      [7:0] REG_RDATA_OUT,
   // System controller configuration bit
   input  wire logic       SC_CFG_WR_IN,
   input  wire logic       SC_CFG_VALUE_IN,
   output logic            SC_BIT_OUT,
   // Interface core state events
   input  wire logic       ANRS_ENTER_IN,
   input  wire logic       END_RX_IN,
   input  wire logic       BYTE_RX_IN,
   input  wire logic       LIDS_ENTER_IN,
   input  wire logic       CPPS_ENTER_IN,
   input  wire logic       CIDS_ENTER_IN,
   input  wire logic       DATA_IN_CLEAR_IN,
   // Source settling inputs
   input  wire logic       BYTE_ON_DIO_IN,
   input  wire logic       XFER_IS_COMMAND_IN,
   input  wire logic       HS_TIMING_SEL_IN,
   // Local messages and status
   output logic            LTN_OUT,
   output logic            LUN_OUT,
   output logic            RDY_OUT,
   output logic            RPP_OUT,
   output logic            RSC_OUT,
   output logic            IFC_OUT,
   output logic            REN_OUT,
   output logic            CONT_MODE_OUT,
   output logic            RFD_HOLDOFF_OUT,
   output logic            DATA_IN_FLAG_OUT,
   output logic            DAV_ENABLE_OUT,
   output logic      [3:0] DIVISOR_OUT
);

   // ==========================================================
   // Helpers
   // ==========================================================
   // Paired set/clear commands share a code apart from the value bit
   function automatic logic is_pair(input logic [4:0] code, input logic [4:0] pair);
      is_pair = ((code & iacu_pkg::PAIR_MASK) == pair);
   endfunction

   // ==========================================================
   // State
   // ==========================================================
   logic [7:0] rdata_r,    rdata_nxt;
   logic       sc_r,       sc_nxt;
   logic       ltn_r,      ltn_nxt;
   logic       lun_r,      lun_nxt;
   logic       rdy_r,      rdy_nxt;
   logic       rpp_r,      rpp_nxt;
   logic       rsc_r,      rsc_nxt;
   logic       ifc_r,      ifc_nxt;
   logic       ren_r,      ren_nxt;
   logic       cont_r,     cont_nxt;
   logic       holdoff_r,  holdoff_nxt;
   logic       din_r,      din_nxt;
   logic [4:0] cdiv_r,     cdiv_nxt;
   logic [3:0] pre_r,      pre_nxt;
   logic [7:0] t1_r,       t1_nxt;
   logic       dav_r,      dav_nxt;
   logic       aux_wr;
   logic       cmd_wr;
   logic [4:0] code;
   logic       val;
   logic       tick;
   logic [3:0] div_limit;
   logic [7:0] t1_need;
   // Decode of the aux mode register write
   assign aux_wr = REG_WR_STB_IN && (REG_ADDR_IN == iacu_pkg::AUX_MODE_ADDR);
   assign code   = REG_WDATA_IN[iacu_pkg::DATA_MSB:0];
   assign val    = REG_WDATA_IN[iacu_pkg::VALUE_BIT];
   assign cmd_wr = aux_wr && (REG_WDATA_IN[iacu_pkg::SEL_MSB:iacu_pkg::SEL_LSB] == iacu_pkg::SEL_AUX_COMMAND);
   // Prescaler tick every divisor cycles, zero counting as 16; the compare is >= so that a
   // count left above a newly lowered limit ticks at once rather than wrapping through 16
   assign div_limit = (cdiv_r[3:0] == 4'h0) ? iacu_pkg::DIV_ZERO_AS : 4'(cdiv_r[3:0] - 4'h1);
   assign tick      = (pre_r >= div_limit);

   // Commands always settle with the long delay; data may use the short one
   assign t1_need = (HS_TIMING_SEL_IN && !XFER_IS_COMMAND_IN) ?
                    iacu_pkg::T1_FAST_TICKS : iacu_pkg::T1_STD_TICKS;

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb
   begin
      rdata_nxt   = iacu_pkg::READ_BACK_VALUE;
      sc_nxt      = sc_r;
      ltn_nxt     = 1'b0;
      lun_nxt     = 1'b0;
      rdy_nxt     = 1'b0;
      rpp_nxt     = rpp_r;
      rsc_nxt     = rsc_r;
      ifc_nxt     = ifc_r;
      ren_nxt     = ren_r;
      cont_nxt    = cont_r;
      holdoff_nxt = holdoff_r;
      din_nxt     = din_r;
      cdiv_nxt    = cdiv_r;
      pre_nxt     = tick ? 4'h0 : 4'(pre_r + 4'h1);
      t1_nxt      = t1_r;
      dav_nxt     = dav_r;

      // Reads of the aux address show nothing of the hidden registers
      if (REG_RD_STB_IN)
         rdata_nxt = iacu_pkg::READ_BACK_VALUE;

      // Configuration write of the system controller bit
      if (SC_CFG_WR_IN)
         sc_nxt = SC_CFG_VALUE_IN;
      // Listener core events in continuous mode; CPPS or CIDS entry clears rpp
      if (cont_r && ANRS_ENTER_IN && !holdoff_r)
      begin
         if (END_RX_IN)
            holdoff_nxt = 1'b1;
         else
            rdy_nxt = 1'b1;
      end
      if (LIDS_ENTER_IN)
      begin
         cont_nxt    = 1'b0;
         holdoff_nxt = 1'b0;
      end
      if (CPPS_ENTER_IN || CIDS_ENTER_IN)
         rpp_nxt = 1'b0;
      // Clear first so that a byte in the same cycle still sets the flag
      if (DATA_IN_CLEAR_IN)
         din_nxt = 1'b0;
      if (BYTE_RX_IN && !cont_r)
         din_nxt = 1'b1;
      // Auxiliary commands; other codes belong to other units and are ignored here
      if (cmd_wr)
      begin
         if (code == iacu_pkg::CMD_LISTEN)
         begin
            ltn_nxt     = 1'b1;
            cont_nxt    = 1'b0;
            holdoff_nxt = 1'b0;
         end
         else if (code == iacu_pkg::CMD_LISTEN_CONT)
         begin
            ltn_nxt     = 1'b1;
            cont_nxt    = 1'b1;
            holdoff_nxt = 1'b0;
         end
         else if (code == iacu_pkg::CMD_LOCAL_UNLISTEN)
            lun_nxt = 1'b1;
         else if (code == iacu_pkg::CMD_EXEC_PPOLL)
            rpp_nxt = 1'b1;
         else if (is_pair(code, iacu_pkg::CMD_IFC_PAIR))
         begin
            rsc_nxt = 1'b1;
            ifc_nxt = val;
         end
         else if (is_pair(code, iacu_pkg::CMD_REN_PAIR))
         begin
            rsc_nxt = 1'b1;
            ren_nxt = val;
         end
         else if (code == iacu_pkg::CMD_DISABLE_SC)
         begin
            rsc_nxt = 1'b0;
            sc_nxt  = 1'b0;
         end
      end
      // Hidden register load; bit 4 is kept as written, the host keeps it zero
      if (aux_wr && (REG_WDATA_IN[iacu_pkg::SEL_MSB:iacu_pkg::SEL_LSB] == iacu_pkg::SEL_COUNTER_DIV))
         cdiv_nxt = code;
      // T1 settling: count ticks while a byte sits on DIO, then allow DAV
      if (!BYTE_ON_DIO_IN)
      begin
         t1_nxt  = 8'h00;
         dav_nxt = 1'b0;
      end
      else if (!dav_r && tick)
      begin
         t1_nxt = 8'(t1_r + 8'h01);
         if (8'(t1_r + 8'h01) >= t1_need)
            dav_nxt = 1'b1;
      end

      // Local master reset returns everything, the divisor included
      if (LOCAL_MASTER_RESET_IN)
      begin
         sc_nxt      = 1'b0;
         rpp_nxt     = 1'b0;
         rsc_nxt     = 1'b0;
         ifc_nxt     = 1'b0;
         ren_nxt     = 1'b0;
         cont_nxt    = 1'b0;
         holdoff_nxt = 1'b0;
         din_nxt     = 1'b0;
         ltn_nxt     = 1'b0;
         lun_nxt     = 1'b0;
         rdy_nxt     = 1'b0;
         cdiv_nxt    = iacu_pkg::COUNTER_DIV_RESET;
         pre_nxt     = 4'h0;
         t1_nxt      = 8'h00;
         dav_nxt     = 1'b0;
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         rdata_r   <= iacu_pkg::READ_BACK_VALUE;
         sc_r      <= 1'b0;
         ltn_r     <= 1'b0;
         lun_r     <= 1'b0;
         rdy_r     <= 1'b0;
         rpp_r     <= 1'b0;
         rsc_r     <= 1'b0;
         ifc_r     <= 1'b0;
         ren_r     <= 1'b0;
         cont_r    <= 1'b0;
         holdoff_r <= 1'b0;
         din_r     <= 1'b0;
         cdiv_r    <= iacu_pkg::COUNTER_DIV_RESET;
         pre_r     <= 4'h0;
         t1_r      <= 8'h00;
         dav_r     <= 1'b0;
      end
      else
      begin
         rdata_r   <= rdata_nxt;
         sc_r      <= sc_nxt;
         ltn_r     <= ltn_nxt;
         lun_r     <= lun_nxt;
         rdy_r     <= rdy_nxt;
         rpp_r     <= rpp_nxt;
         rsc_r     <= rsc_nxt;
         ifc_r     <= ifc_nxt;
         ren_r     <= ren_nxt;
         cont_r    <= cont_nxt;
         holdoff_r <= holdoff_nxt;
         din_r     <= din_nxt;
         cdiv_r    <= cdiv_nxt;
         pre_r     <= pre_nxt;
         t1_r      <= t1_nxt;
         dav_r     <= dav_nxt;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   // ==========================================================
   assign REG_RDATA_OUT    = rdata_r;
   assign SC_BIT_OUT       = sc_r;
   assign LTN_OUT          = ltn_r;
   assign LUN_OUT          = lun_r;
   assign RDY_OUT          = rdy_r;
   assign RPP_OUT          = rpp_r;
   assign RSC_OUT          = rsc_r;
   assign IFC_OUT          = ifc_r;
   assign REN_OUT          = ren_r;
   assign CONT_MODE_OUT    = cont_r;
   assign RFD_HOLDOFF_OUT  = holdoff_r;
   assign DATA_IN_FLAG_OUT = din_r;
   assign DAV_ENABLE_OUT   = dav_r;
   assign DIVISOR_OUT      = cdiv_r[3:0];

endmodule

// ### iacu_aux_command_unit_asserts.sv
module iacu_aux_command_unit_asserts
(
   // Clock, resets, host port
   input wire logic       REF_CLK_IN,
   input wire logic       RST_N_IN,
   input wire logic       LOCAL_MASTER_RESET_IN,
   input wire logic [8:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic       REG_WR_STB_IN,
   input wire logic       REG_RD_STB_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   // Core events
   input wire logic       ANRS_ENTER_IN,
   input wire logic       END_RX_IN,
   input wire logic       LIDS_ENTER_IN,
   input wire logic       CPPS_ENTER_IN,
   input wire logic       CIDS_ENTER_IN,
   // Messages and status
   input wire logic       LTN_OUT,
   input wire logic       LUN_OUT,
   input wire logic       RDY_OUT,
   input wire logic       RPP_OUT,
   input wire logic       RSC_OUT,
   input wire logic       IFC_OUT,
   input wire logic       REN_OUT,
   input wire logic       SC_BIT_OUT,
   input wire logic       CONT_MODE_OUT,
   input wire logic       RFD_HOLDOFF_OUT,
   input wire logic       DATA_IN_FLAG_OUT,
   input wire logic [3:0] DIVISOR_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Accepted aux write; a local reset in the same cycle discards it
   wire aw = REG_WR_STB_IN && REG_ADDR_IN == iacu_pkg::AUX_MODE_ADDR && !LOCAL_MASTER_RESET_IN;
   // No competing write, LIDS or reset, so ANRS alone decides
   wire quiet = !REG_WR_STB_IN && !LIDS_ENTER_IN && !LOCAL_MASTER_RESET_IN;
   // ==========
   // Assertions
   chk_ltn_cont: assert property (aw && REG_WDATA_IN == 8'h1b |=> LTN_OUT && CONT_MODE_OUT)
      else $error("listen-cont missed");
   chk_ltn_cause: assert property (LTN_OUT |-> $past(aw && REG_WDATA_IN == 8'h13 ||
      aw && REG_WDATA_IN == 8'h1b))
      else $error("ltn without command");
   chk_lun_cause: assert property (LUN_OUT |-> $past(aw && REG_WDATA_IN == 8'h1c))
      else $error("lun without command");
   chk_rdy_anrs: assert property (ANRS_ENTER_IN && CONT_MODE_OUT && !RFD_HOLDOFF_OUT && quiet
      |=> RDY_OUT == !$past(END_RX_IN))
      else $error("rdy wrong on ANRS");
   chk_end_holdoff: assert property (ANRS_ENTER_IN && CONT_MODE_OUT && END_RX_IN && quiet
      |=> RFD_HOLDOFF_OUT && !RDY_OUT)
      else $error("END did not hold off");
   chk_di_cont: assert property (CONT_MODE_OUT && !DATA_IN_FLAG_OUT |=> !DATA_IN_FLAG_OUT)
      else $error("data-in set in continuous mode");
   chk_lids_ends: assert property (LIDS_ENTER_IN && !REG_WR_STB_IN |=> !CONT_MODE_OUT)
      else $error("LIDS kept continuous mode");
   chk_rpp_clear: assert property ((CPPS_ENTER_IN || CIDS_ENTER_IN) && !REG_WR_STB_IN |=> !RPP_OUT)
      else $error("rpp not cleared");
   chk_ifc_value: assert property (aw && (REG_WDATA_IN & 8'hf7) == 8'h16
      |=> RSC_OUT && IFC_OUT == $past(REG_WDATA_IN[3]))
      else $error("IFC command wrong");
   chk_ren_value: assert property (aw && (REG_WDATA_IN & 8'hf7) == 8'h17
      |=> RSC_OUT && REN_OUT == $past(REG_WDATA_IN[3]))
      else $error("REN command wrong");
   chk_sc_disable: assert property (aw && REG_WDATA_IN == 8'h14 |=> !RSC_OUT && !SC_BIT_OUT)
      else $error("disable system control failed");
   chk_div_load: assert property (aw && REG_WDATA_IN[7:5] == 3'h1
      |=> DIVISOR_OUT == $past(REG_WDATA_IN[3:0]))
      else $error("divisor not loaded");
   chk_read_hidden: assert property (REG_RD_STB_IN |=> REG_RDATA_OUT == 8'h00)
      else $error("hidden contents read back");
   // Main scenarios reached
   cover property (RDY_OUT);
   cover property (RFD_HOLDOFF_OUT && CONT_MODE_OUT);
   cover property (aw && REG_WDATA_IN[7:5] == 3'h1);
endmodule

bind iacu_aux_command_unit iacu_aux_command_unit_asserts chk_u (.*);

// ### iacu_bus_partner.sv
module iacu_bus_partner
(
   // Clock
   input  wire logic       clk_in,
   // State entries: 0 ANRS, 1 byte, 2 LIDS, 3 CPPS, 4 CIDS
   output logic      [4:0] ev_out,
   output logic            end_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // One strobe set per cycle; END means nothing outside ANRS, so it
   // shows the inverse of its last value rather than a stale match
   task automatic fire(input logic [4:0] m, input logic e);
      ev_out = m;
      end_out = m[0] ? e : ~end_out;
   endtask
endmodule

// ### iacu_aux_command_unit_tb.sv
module iacu_aux_command_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0] AUX = iacu_pkg::AUX_MODE_ADDR;
   // Ops: [15:8] data, [7:3] events, [2] END, [0] write
   localparam logic [15:0] SEQ [18] = '{16'h1b01, 16'h0008, 16'h0010, 16'h000c, 16'h0008, 16'h1b01,
      16'h0020, 16'h0010, 16'h1b01, 16'h1301, 16'h1c01, 16'h1c01, 16'h1d01, 16'h0040, 16'h1d01,
      16'h0080, 16'h2f01, 16'hef01};
   // T1 cases: divisor, high-speed, command
   localparam logic [5:0] T1C [5] = '{6'h04, 6'h0a, 6'h0b, 6'h20, 6'h02};
   // ==========
   // Signals
   logic        REF_CLK_IN, RST_N_IN, LOCAL_MASTER_RESET_IN, REG_WR_STB_IN, REG_RD_STB_IN;
   logic        SC_CFG_WR_IN, SC_CFG_VALUE_IN, DATA_IN_CLEAR_IN, BYTE_ON_DIO_IN, END_RX_IN;
   logic        XFER_IS_COMMAND_IN, HS_TIMING_SEL_IN, ANRS_ENTER_IN, BYTE_RX_IN;
   logic        LIDS_ENTER_IN, CPPS_ENTER_IN, CIDS_ENTER_IN, DAV_ENABLE_OUT;
   logic [8:0]  REG_ADDR_IN;
   logic [7:0]  REG_WDATA_IN, REG_RDATA_OUT, d;
   logic        LTN_OUT, LUN_OUT, RDY_OUT, RPP_OUT, RSC_OUT, IFC_OUT, REN_OUT, SC_BIT_OUT;
   logic        CONT_MODE_OUT, RFD_HOLDOFF_OUT, DATA_IN_FLAG_OUT;
   logic [3:0]  DIVISOR_OUT;
   logic [4:0]  ev, e, p, m_div;
   logic        m_ltn, m_lun, m_rdy, m_rpp, m_rsc, m_ifc, m_ren, m_cont, m_hold, m_di, m_sc;
   logic [31:0] r, seed = 32'd99;
   int          mismatches = 0, n_compared = 0, n, k, need;
   wire         aw = REG_WR_STB_IN && REG_ADDR_IN == AUX;
   wire [22:0]  got_v = {REG_RDATA_OUT, LTN_OUT, LUN_OUT, RDY_OUT, RPP_OUT, RSC_OUT, IFC_OUT,
      REN_OUT, SC_BIT_OUT, CONT_MODE_OUT, RFD_HOLDOFF_OUT, DATA_IN_FLAG_OUT, DIVISOR_OUT};
   wire [22:0]  exp_v = {8'h00, m_ltn, m_lun, m_rdy, m_rpp, m_rsc, m_ifc, m_ren, m_sc, m_cont,
      m_hold, m_di, m_div[3:0]};
   assign {CIDS_ENTER_IN, CPPS_ENTER_IN, LIDS_ENTER_IN, BYTE_RX_IN, ANRS_ENTER_IN} = ev;
   iacu_aux_command_unit dut_u (.*);
   iacu_bus_partner p_u (.clk_in(REF_CLK_IN), .ev_out(ev), .end_out(END_RX_IN));
   // ==========
   // Tasks
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [22:0] g, input logic [22:0] x);
      n_compared++;
      if (g !== x)
      begin
         mismatches++;
         $display("[FAIL] %0t outputs %h expected %h", $time, g, x);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      n_compared++;
      if (v < lo || v > hi)
      begin
         mismatches++;
         $display("[FAIL] %0t delay %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask
   // One cycle: strobes {wr, rd, sc load, data-in clear, local reset}
   task automatic step(input logic [4:0] s, input logic [8:0] a, input logic [7:0] v,
      input logic [4:0] m, input logic x);
      {REG_WR_STB_IN, REG_RD_STB_IN, SC_CFG_WR_IN, DATA_IN_CLEAR_IN, LOCAL_MASTER_RESET_IN} = s;
      REG_ADDR_IN = a;
      REG_WDATA_IN = v;
      SC_CFG_VALUE_IN = v[0];
      p_u.fire(m, x);
      @(posedge REF_CLK_IN);
      #2;
   endtask
   task automatic idle();
      step(5'h00, 9'h000, 8'h00, 5'h00, 1'b0);
   endtask
   task automatic wr(input logic [7:0] v);
      step(5'h10, AUX, v, 5'h00, 1'b0);
   endtask
   // ==========
   // Reference model, updated on the design's edge
   always @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN || LOCAL_MASTER_RESET_IN)
      begin
         {m_ltn, m_lun, m_rdy, m_rpp, m_rsc, m_ifc, m_ren, m_cont, m_hold, m_di, m_sc} = '0;
         m_div = iacu_pkg::COUNTER_DIV_RESET;
      end
      else
      begin
         {m_ltn, m_lun, m_rdy} = 3'h0;
         if (ANRS_ENTER_IN && m_cont && !m_hold)
            {m_rdy, m_hold} = {!END_RX_IN, END_RX_IN};
         m_di = (m_di && !DATA_IN_CLEAR_IN) || (BYTE_RX_IN && !m_cont);
         {m_cont, m_hold} = LIDS_ENTER_IN ? 2'b00 : {m_cont, m_hold};
         m_rpp = m_rpp && !CPPS_ENTER_IN && !CIDS_ENTER_IN;
         m_sc = SC_CFG_WR_IN ? SC_CFG_VALUE_IN : m_sc;
         m_div = (aw && REG_WDATA_IN[7:5] == 3'h1) ? REG_WDATA_IN[4:0] : m_div;
         if (aw && REG_WDATA_IN[7:5] == 3'h0)
            case (REG_WDATA_IN[4:0])
               5'h13, 5'h1b: {m_ltn, m_cont, m_hold} = {1'b1, REG_WDATA_IN[3], 1'b0};
               5'h1c: m_lun = 1'b1;
               5'h1d: m_rpp = 1'b1;
               5'h16, 5'h1e: {m_rsc, m_ifc} = {1'b1, REG_WDATA_IN[3]};
               5'h17, 5'h1f: {m_rsc, m_ren} = {1'b1, REG_WDATA_IN[3]};
               5'h14: {m_rsc, m_sc} = 2'b00;
               default: ;
            endcase
      end
   end
   // Settled outputs checked every cycle
   always @(negedge REF_CLK_IN) chk(got_v, exp_v);
   initial
   begin
      REF_CLK_IN = 1'b0;
      forever #20 REF_CLK_IN = ~REF_CLK_IN;
   end
   // ==========
   // Main sequence
   initial
   begin
      {RST_N_IN, BYTE_ON_DIO_IN, XFER_IS_COMMAND_IN, HS_TIMING_SEL_IN} = 4'h0;
      repeat (5) idle();
      RST_N_IN = 1'b1;
      foreach (SEQ[i]) step({SEQ[i][0], 4'h0}, AUX, SEQ[i][15:8], SEQ[i][7:3], SEQ[i][2]);
      step(5'h04, AUX, 8'h01, 5'h00, 1'b0);
      wr(8'h1e);
      repeat (2500) idle();
      wr(8'h16);
      wr(8'h1f);
      wr(8'h17);
      wr(8'h14);
      foreach (T1C[i])
      begin
         k = (T1C[i][5:2] == 4'h0) ? 16 : int'(T1C[i][5:2]);
         need = (T1C[i][1] && !T1C[i][0]) ? 4 : 16;
         wr({4'h2, T1C[i][5:2]});
         {HS_TIMING_SEL_IN, XFER_IS_COMMAND_IN, BYTE_ON_DIO_IN} = {T1C[i][1:0], 1'b1};
         for (n = 0; n < 400 && DAV_ENABLE_OUT !== 1'b1; n++)
            idle();
         rng(n, need * k - k, need * k + 1);
         if (n == 400)
            end_sim();
         BYTE_ON_DIO_IN = 1'b0;
         idle();
         chk({22'h0, DAV_ENABLE_OUT}, 23'h0);
      end
      for (int i = 0; i < 3000; i++)
      begin
         r = rnd();
         d = r[15:8];
         if (d[7:5] == 3'h0 && (d[4:0] & 5'h16) == 5'h16)
            d = 8'h1b; // IFC and REN keep to the timed sequence
         if (d[7:5] == 3'h1)
            d[4] = 1'b0;
         e = (r[18:16] < 3'h5) ? 5'h01 << r[18:16] : 5'h00;
         p = (e != 5'h00) ? 5'h00 : {r[19], r[20], r[21], r[22], r[31:26] == 6'h00};
         // One command per write, so no two auxiliary commands are ever issued together
         step(p, r[23] ? AUX : 9'h11a, d, e, r[24]);
      end
      RST_N_IN = 1'b0;
      repeat (2) idle();
      RST_N_IN = 1'b1;
      wr(8'h1b);
      idle();
      end_sim();
   end
endmodule
